// *** pwtc_device.sv ***
// Device end: serial slave holding the timing settings, plus per-channel
// period and ADC-sample timing with phase offsets.
// Assumes link lines are asynchronous to core_clk_i; reply is shifted out
// during the frame that follows the request.
`timescale 1ns/100ps
`default_nettype none
module pwtc_device #(
    parameter int NUM_CH = pwtc_pkg::NUM_CH
) (
    // Clock and reset
    input  wire logic                                     core_clk_i,
    input  wire logic                                     rstn_i,
    // Serial link
    pwtc_link_if.dev                                      link,
    // Alignment and mode
    input  wire logic                                     phase_sync_i,
    input  wire logic                                     current_mode_i,
    output logic                                          phase_aligned_o,
    // Timing outputs
    output logic [NUM_CH-1:0]                             period_start_o,
    output logic [NUM_CH-1:0]                             adc_sample_o,
    // Settings to the control loops
    output logic [NUM_CH-1:0]                             sample_sum_method_o,
    output logic [NUM_CH-1:0][pwtc_pkg::GAIN_W-1:0]       kp_o,
    output logic [NUM_CH-1:0][pwtc_pkg::GAIN_W-1:0]       ki_o
);
    import pwtc_pkg::*;

    // Input synchronisers: stage 1, stage 2, and a delayed copy for edges
    logic [3:0] sync1_r, sync2_r, prev_r;
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1_r <= 4'hF;
            sync2_r <= 4'hF;
            prev_r  <= 4'hF;
        end else begin
            sync1_r <= {phase_sync_i, link.mosi, link.cs_n, link.sclk};
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end
    logic sclk_s, cs_s, mosi_s, psync_s;
    assign sclk_s  = sync2_r[0];
    assign cs_s    = sync2_r[1];
    assign mosi_s  = sync2_r[2];
    assign psync_s = sync2_r[3];
    logic sclk_rise, sclk_fall, cs_fall, cs_rise, sync_pulse;
    assign sclk_rise  = sclk_s & ~prev_r[0] & ~cs_s;
    assign sclk_fall  = ~sclk_s & prev_r[0] & ~cs_s;
    assign cs_fall    = ~cs_s & prev_r[1];
    assign cs_rise    = cs_s & ~prev_r[1];
    // Sync pin idles low; only its rising edge counts
    assign sync_pulse = psync_s & ~prev_r[3];

    // Settings and link state
    logic [NUM_CH-1:0][OFF_W-1:0]  off_r, off_nxt;
    logic [NUM_CH-1:0]             sam_r, sam_nxt;
    logic [NUM_CH-1:0][1:0]        mdiv_r, mdiv_nxt;
    logic [NUM_CH-1:0][NDIV_W-1:0] ndiv_r, ndiv_nxt;
    logic [NUM_CH-1:0][GAIN_W-1:0] kp_r, kp_nxt, ki_r, ki_nxt;
    logic [31:0] rx_r, rx_nxt, tx_r, tx_nxt, resp_r, resp_nxt;
    logic [5:0]  cnt_r, cnt_nxt;
    logic        aligned_r, aligned_nxt;

    logic        wr;
    logic [6:0]  id7;
    logic [3:0]  id4;
    logic [2:0]  ch;
    assign wr  = rx_r[RW_BIT];
    assign id7 = rx_r[ID7_HI:ID7_LO];
    assign id4 = rx_r[ID7_HI:ID4_LO];
    assign ch  = rx_r[CH_HI:CH_LO];

    always_comb begin
        off_nxt     = off_r;
        sam_nxt     = sam_r;
        mdiv_nxt    = mdiv_r;
        ndiv_nxt    = ndiv_r;
        kp_nxt      = kp_r;
        ki_nxt      = ki_r;
        rx_nxt      = rx_r;
        tx_nxt      = tx_r;
        resp_nxt    = resp_r;
        cnt_nxt     = cnt_r;
        // Alignment is lost only at reset
        aligned_nxt = aligned_r | sync_pulse;
        if (cs_fall) begin
            tx_nxt  = resp_r;
            cnt_nxt = 6'h00;
        end else if (sclk_rise) begin
            rx_nxt  = {rx_r[30:0], mosi_s};
            cnt_nxt = (cnt_r > FRAME_BITS_M1) ? cnt_r : cnt_r + 6'h01;
        end else if (sclk_fall) begin
            tx_nxt  = {tx_r[30:0], 1'b0};
        end
        // Frames of 32 bits or more are taken, last 32 bits kept; a short frame is dropped and replies zero
        if (cs_rise) begin
            resp_nxt = 32'h0000_0000;
            if (cnt_r == 6'(FRAME_BITS)) begin
                if (id7 == MSG_OFF_LOW || id7 == MSG_OFF_HIGH) begin
                    for (int i = 0; i < 4; i++) begin
                        if (wr) begin
                            off_nxt[{id7[0], 2'(i)}] = rx_r[i*OFF_W +: OFF_W];
                        end
                        resp_nxt[i*OFF_W +: OFF_W] = off_nxt[{id7[0], 2'(i)}];
                    end
                    resp_nxt[ID7_HI:ID7_LO] = id7;
                end else if (id4 == MSG_PERIOD) begin
                    if (wr) begin
                        sam_nxt[ch]  = rx_r[SAM_BIT];
                        mdiv_nxt[ch] = rx_r[MDIV_HI:MDIV_LO];
                        ndiv_nxt[ch] = rx_r[NDIV_W-1:0];
                    end
                    resp_nxt[ID7_HI:CH_LO]     = {id4, ch};
                    resp_nxt[SAM_BIT]          = sam_nxt[ch];
                    resp_nxt[MDIV_HI:MDIV_LO]  = mdiv_nxt[ch];
                    resp_nxt[NDIV_W-1:0]       = ndiv_nxt[ch];
                end else if (id4 == MSG_GAINS) begin
                    if (wr) begin
                        kp_nxt[ch] = rx_r[KP_LO +: GAIN_W];
                        ki_nxt[ch] = rx_r[GAIN_W-1:0];
                    end
                    resp_nxt[ID7_HI:CH_LO]      = {id4, ch};
                    resp_nxt[KP_LO +: GAIN_W]   = kp_nxt[ch];
                    resp_nxt[GAIN_W-1:0]        = ki_nxt[ch];
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            off_r     <= {NUM_CH{OFF_RST}};
            sam_r     <= {NUM_CH{SAM_RST}};
            mdiv_r    <= {NUM_CH{MDIV_RST}};
            ndiv_r    <= {NUM_CH{NDIV_RST}};
            kp_r      <= {NUM_CH{GAIN_RST}};
            ki_r      <= {NUM_CH{GAIN_RST}};
            rx_r      <= 32'h0000_0000;
            tx_r      <= 32'h0000_0000;
            resp_r    <= 32'h0000_0000;
            cnt_r     <= 6'h00;
            aligned_r <= 1'b0;
        end else begin
            off_r     <= off_nxt;
            sam_r     <= sam_nxt;
            mdiv_r    <= mdiv_nxt;
            ndiv_r    <= ndiv_nxt;
            kp_r      <= kp_nxt;
            ki_r      <= ki_nxt;
            rx_r      <= rx_nxt;
            tx_r      <= tx_nxt;
            resp_r    <= resp_nxt;
            cnt_r     <= cnt_nxt;
            aligned_r <= aligned_nxt;
        end
    end

    assign link.miso           = tx_r[31];
    assign phase_aligned_o     = aligned_r;
    assign sample_sum_method_o = sam_r;
    assign kp_o                = kp_r;
    assign ki_o                = ki_r;

    // Per-channel period and sample timing
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        logic [PERIOD_W-1:0]          period, start_val;
        logic [PERIOD_W+OFF_W-1:0]    prod;
        logic [PERIOD_W-1:0]          delay;
        logic [PERIOD_W-1:0]          pcnt_r, pcnt_nxt;
        logic [NDIV_W-1:0]            acnt_r, acnt_nxt;
        logic                         pstart_r, pstart_nxt, asmp_r, asmp_nxt;

        // Period settings take effect at once, offsets at the next sync pulse; a period in flight may be cut short
        // Operands widened first so neither product wraps at its operand width
        assign period    = PERIOD_W'(ndiv_r[g])
                         * PERIOD_W'(pwtc_samples(mdiv_r[g], current_mode_i));
        assign prod      = (PERIOD_W+OFF_W)'(period) * (PERIOD_W+OFF_W)'(off_r[g]);
        assign delay     = prod[PHASE_STEPS_LOG2 +: PERIOD_W];
        assign start_val = (delay == '0) ? '0 : period - delay;

        always_comb begin
            if (sync_pulse) begin
                pcnt_nxt = start_val;
            end else if (pcnt_r + 1'b1 >= period) begin
                pcnt_nxt = '0;
            end else begin
                pcnt_nxt = pcnt_r + 1'b1;
            end
            // Sample spacing restarts with each period
            if (pcnt_nxt == '0 || acnt_r + 1'b1 >= ndiv_r[g]) begin
                acnt_nxt = '0;
            end else begin
                acnt_nxt = acnt_r + 1'b1;
            end
            pstart_nxt = (pcnt_nxt == '0);
            asmp_nxt   = (acnt_nxt == '0);
        end

        always_ff @(posedge core_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                pcnt_r   <= '0;
                acnt_r   <= '0;
                pstart_r <= 1'b0;
                asmp_r   <= 1'b0;
            end else begin
                pcnt_r   <= pcnt_nxt;
                acnt_r   <= acnt_nxt;
                pstart_r <= pstart_nxt;
                asmp_r   <= asmp_nxt;
            end
        end
        assign period_start_o[g] = pstart_r;
        assign adc_sample_o[g]   = asmp_r;
    end
endmodule : pwtc_device
`default_nettype wire

// *** pwtc_pkg.sv ***
// Package for the serial timing set-up block: message codes, field layout,
// reset values and link timing shared by the device end and the host end.
// Assumes a single core clock of 50 MHz on both ends.
// Notes on behaviour
// - Identifier 0000110 addresses offsets of channels 0-3
// - Identifier 0000111 addresses offsets of channels 4-7
// - Five-bit offsets delay pulse by offset/32 period
// - Phase-sync pulse restarts all channels with offsets
// - Identifier 0001 plus channel selects period settings
// - Bit 16 picks sample summation method
// - Bits 15:14 pick 32, 64 or 128 samples
// - Code 11 gives 512 direct, 128 current mode
// - Bits 13:0 are sample interval, reset 625
// - Period is interval times samples, ADC interval alone
// - Identifier 0010 plus channel selects loop gains
// - Twelve-bit proportional and integral gains, reset zero
`default_nettype none
package pwtc_pkg;
    localparam int NUM_CH = 8;
    localparam int FRAME_BITS = 32;
    localparam logic [5:0] FRAME_BITS_M1 = 6'h1F;
    // Message field positions
    localparam int RW_BIT = 31;
    localparam int ID7_HI = 30;
    localparam int ID7_LO = 24;
    localparam int ID4_LO = 27;
    localparam int CH_HI = 26;
    localparam int CH_LO = 24;
    localparam int OFF_W = 5;
    localparam int SAM_BIT = 16;
    localparam int MDIV_HI = 15;
    localparam int MDIV_LO = 14;
    localparam int NDIV_W = 14;
    localparam int GAIN_W = 12;
    localparam int KP_LO = 12;
    // Message selectors
    localparam logic [6:0] MSG_OFF_LOW = 7'h06;
    localparam logic [6:0] MSG_OFF_HIGH = 7'h07;
    localparam logic [3:0] MSG_PERIOD = 4'h1;
    localparam logic [3:0] MSG_GAINS = 4'h2;
    // Samples-per-period codes and counts
    localparam logic [1:0] MDIV_32 = 2'h0;
    localparam logic [1:0] MDIV_64 = 2'h1;
    localparam logic [1:0] MDIV_128 = 2'h2;
    localparam logic [9:0] SAMPLES_32 = 10'h020;
    localparam logic [9:0] SAMPLES_64 = 10'h040;
    localparam logic [9:0] SAMPLES_128 = 10'h080;
    localparam logic [9:0] SAMPLES_512 = 10'h200;
    localparam int PERIOD_W = NDIV_W + 10;
    localparam int PHASE_STEPS_LOG2 = 5;
    // Reset values
    localparam logic [OFF_W-1:0] OFF_RST = 5'h00;
    localparam logic SAM_RST = 1'b0;
    localparam logic [1:0] MDIV_RST = 2'h0;
    localparam logic [NDIV_W-1:0] NDIV_RST = 14'h0271;
    localparam logic [GAIN_W-1:0] GAIN_RST = 12'h000;
    // Link timing: host serial clock period in ns, halved into core cycles
    localparam int CORE_PERIOD_NS = 20;
    localparam int SCLK_PERIOD_NS = 160;
    localparam int SCLK_HALF_CYC = (SCLK_PERIOD_NS / 2 + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    // Host command port addresses
    localparam logic [1:0] HOST_ADDR_TX = 2'h0;
    localparam logic [1:0] HOST_ADDR_RX = 2'h1;
    localparam logic [1:0] HOST_ADDR_STAT = 2'h2;

    function automatic logic [9:0] pwtc_samples(input logic [1:0] code, input logic cur_mode);
        logic [9:0] s;
        s = SAMPLES_32;
        unique case (code)
            MDIV_32:  s = SAMPLES_32;
            MDIV_64:  s = SAMPLES_64;
            MDIV_128: s = SAMPLES_128;
            default:  s = cur_mode ? SAMPLES_128 : SAMPLES_512;
        endcase
        return s;
    endfunction : pwtc_samples
endpackage : pwtc_pkg
`default_nettype wire

// *** pwtc_link_if.sv ***
// Serial link between host (master) and the timing set-up device.
// Both ends run on their own core clock and sample the other's lines.
`timescale 1ns/100ps
`default_nettype none
interface pwtc_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    modport dev  (input sclk, input cs_n, input mosi, output miso);
    modport host (output sclk, output cs_n, output mosi, input miso);
endinterface : pwtc_link_if
`default_nettype wire

// *** pwtc_host.sv ***
// Host end: serial link master driven from a small command port.
// Assumes the device replies in the next frame; the reply word of a frame
// belongs to the previous request.
`timescale 1ns/100ps
`default_nettype none
module pwtc_host #(
    parameter int HALF_CYC = pwtc_pkg::SCLK_HALF_CYC
) (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rstn_i,
    // Command port
    input  wire logic [1:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [31:0]      rdata_o,
    // Serial link
    pwtc_link_if.host        link
);
    import pwtc_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_HIGH, S_LOW, S_TAIL, S_GAP} pwtc_hst_type;

    pwtc_hst_type st_r, st_nxt;
    logic [31:0]  tx_r, tx_nxt, sh_r, sh_nxt, rx_r, rx_nxt, rxw_r, rxw_nxt, rd_r, rd_nxt;
    logic [7:0]   div_r, div_nxt;
    logic [4:0]   bit_r, bit_nxt;
    logic         sclk_r, sclk_nxt, cs_r, cs_nxt, done_r, done_nxt;
    logic         miso1_r, miso2_r, tick, busy;

    // Miso is asynchronous to this clock
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            miso1_r <= 1'b0;
            miso2_r <= 1'b0;
        end else begin
            miso1_r <= link.miso;
            miso2_r <= miso1_r;
        end
    end

    assign tick = (div_r == 8'(HALF_CYC - 1));
    assign busy = (st_r != S_IDLE);

    always_comb begin
        st_nxt   = st_r;
        tx_nxt   = tx_r;
        sh_nxt   = sh_r;
        rx_nxt   = rx_r;
        rxw_nxt  = rxw_r;
        bit_nxt  = bit_r;
        sclk_nxt = sclk_r;
        cs_nxt   = cs_r;
        div_nxt  = tick ? 8'h00 : div_r + 8'h01;
        done_nxt = done_r;
        // Reading the reply clears the done flag; a new completion wins
        if (rd_i && addr_i == HOST_ADDR_RX) begin
            done_nxt = 1'b0;
        end
        rd_nxt = 32'h0000_0000;
        if (rd_i) begin
            unique case (addr_i)
                HOST_ADDR_TX:   rd_nxt = tx_r;
                HOST_ADDR_RX:   rd_nxt = rxw_r;
                HOST_ADDR_STAT: rd_nxt = {30'h0, done_r, busy};
                default:        rd_nxt = 32'h0000_0000;
            endcase
        end
        unique case (st_r)
            S_IDLE: begin
                div_nxt = 8'h00;
                // Writes while a frame runs are dropped
                if (wr_i && addr_i == HOST_ADDR_TX) begin
                    tx_nxt  = wdata_i;
                    sh_nxt  = wdata_i;
                    cs_nxt  = 1'b0;
                    bit_nxt = 5'h00;
                    st_nxt  = S_SETUP;
                end
            end
            S_SETUP: if (tick) begin
                sclk_nxt = 1'b1;
                st_nxt   = S_HIGH;
            end
            S_HIGH: if (tick) begin
                sclk_nxt = 1'b0;
                rx_nxt   = {rx_r[30:0], miso2_r};
                bit_nxt  = bit_r + 5'h01;
                sh_nxt   = {sh_r[30:0], 1'b0};
                st_nxt   = (bit_r == FRAME_BITS_M1[4:0]) ? S_TAIL : S_LOW;
            end
            S_LOW: if (tick) begin
                sclk_nxt = 1'b1;
                st_nxt   = S_HIGH;
            end
            S_TAIL: if (tick) begin
                cs_nxt   = 1'b1;
                rxw_nxt  = rx_r;
                done_nxt = 1'b1;
                st_nxt   = S_GAP;
            end
            S_GAP: if (tick) begin
                st_nxt = S_IDLE;
            end
            default: st_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r   <= S_IDLE;
            tx_r   <= 32'h0000_0000;
            sh_r   <= 32'h0000_0000;
            rx_r   <= 32'h0000_0000;
            rxw_r  <= 32'h0000_0000;
            rd_r   <= 32'h0000_0000;
            div_r  <= 8'h00;
            bit_r  <= 5'h00;
            sclk_r <= 1'b0;
            cs_r   <= 1'b1;
            done_r <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            tx_r   <= tx_nxt;
            sh_r   <= sh_nxt;
            rx_r   <= rx_nxt;
            rxw_r  <= rxw_nxt;
            rd_r   <= rd_nxt;
            div_r  <= div_nxt;
            bit_r  <= bit_nxt;
            sclk_r <= sclk_nxt;
            cs_r   <= cs_nxt;
            done_r <= done_nxt;
        end
    end

    assign link.sclk = sclk_r;
    assign link.cs_n = cs_r;
    assign link.mosi = cs_r ? 1'b0 : sh_r[31];
    assign rdata_o   = rd_r;
endmodule : pwtc_host
`default_nettype wire

// *** pwtc_properties.sv ***
// Checker for the serial link between the host end and the device end.
// Assumes both ends share core_clk_i and rstn_i; sees only the link lines.
`timescale 1ns/100ps
`default_nettype none
module pwtc_properties (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Link lines
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso
);
    import pwtc_pkg::*;
    logic        sclk_r;
    logic        cs_r;
    logic        pok_r;
    logic [5:0]  cnt_r;
    logic [31:0] req_r;
    logic [31:0] rsp_r;
    logic [31:0] prq_r;
    // Mosi taken at rise, miso at fall: each is mid-bit there
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sclk_r <= 1'b0;
            cs_r   <= 1'b1;
            pok_r  <= 1'b0;
            cnt_r  <= 6'h00;
            req_r  <= 32'h0;
            rsp_r  <= 32'h0;
            prq_r  <= 32'h0;
        end else begin
            sclk_r <= sclk;
            cs_r   <= cs_n;
            if (!cs_n && sclk && !sclk_r) begin
                req_r <= {req_r[30:0], mosi};
                cnt_r <= cnt_r + 6'h01;
            end
            if (!cs_n && !sclk && sclk_r) rsp_r <= {rsp_r[30:0], miso};
            if (cs_n && !cs_r) begin
                prq_r <= req_r;
                pok_r <= (cnt_r == 6'h20);
            end
            if (!cs_n && cs_r) cnt_r <= 6'h00;
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    // Frame end with whole frames now and before: reply pairs with prq_r
    sequence s_pair;
        cs_n && !cs_r && pok_r && cnt_r == 6'h20;
    endsequence
    sequence s_wr_of(logic [3:0] id);
        s_pair ##0 (prq_r[31] && prq_r[30:27] == id);
    endsequence
    chk_idle_quiet: assert property (cs_n |-> !sclk && !mosi)
        else $error("link not quiet outside frame");
    chk_frame_gap: assert property ($rose(cs_n) |-> cs_n [*4])
        else $error("frame gap too short");
    chk_reply_msb: assert property (s_pair |-> !rsp_r[31])
        else $error("reply bit 31 set");
    chk_low_echo: assert property (s_pair ##0 prq_r[30:24] == MSG_OFF_LOW
        |-> rsp_r[30:20] == {MSG_OFF_LOW, 4'h0}) else $error("low offset echo wrong");
    chk_high_echo: assert property (s_pair ##0 prq_r[30:24] == MSG_OFF_HIGH
        |-> rsp_r[30:20] == {MSG_OFF_HIGH, 4'h0}) else $error("high offset echo wrong");
    chk_period_echo: assert property (s_pair ##0 prq_r[30:27] == MSG_PERIOD
        |-> rsp_r[30:17] == {prq_r[30:24], 7'h00}) else $error("period echo wrong");
    chk_gain_echo: assert property (s_pair ##0 prq_r[30:27] == MSG_GAINS
        |-> rsp_r[30:24] == prq_r[30:24]) else $error("gain echo wrong");
    chk_gain_write: assert property (s_wr_of(MSG_GAINS)
        |-> rsp_r[23:0] == prq_r[23:0]) else $error("gain write not returned");
    chk_period_write: assert property (s_wr_of(MSG_PERIOD)
        |-> rsp_r[16:0] == prq_r[16:0]) else $error("period write not returned");
    chk_unknown_zero: assert property (s_pair ##0 (prq_r[30:27] != MSG_PERIOD
        && prq_r[30:27] != MSG_GAINS && prq_r[30:25] != 6'h03)
        |-> rsp_r == 32'h0) else $error("unknown message reply not zero");
endmodule : pwtc_properties
`default_nettype wire

// *** pwm_timing_config_tb_top.sv ***
// Testbench: host end and device end joined by the link interface.
// Assumes the host command port timing and device pulses of the design.
`timescale 1ns/100ps
`default_nettype none
module pwm_timing_config_tb_top;
    import pwtc_pkg::*;
    logic                          core_clk = 1'b0;
    logic                          rstn = 1'b0;
    logic [1:0]                    addr = 2'h0;
    logic [31:0]                   wdata = 32'h0;
    logic                          wr = 1'b0;
    logic                          rd = 1'b0;
    logic                          sync = 1'b0;
    logic                          cmode = 1'b0;
    logic [31:0]                   rdata;
    logic                          aligned;
    logic [NUM_CH-1:0]             pstart;
    logic [NUM_CH-1:0]             adc;
    logic [NUM_CH-1:0]             sample_sum_method;
    logic [NUM_CH-1:0][GAIN_W-1:0] kp;
    logic [NUM_CH-1:0][GAIN_W-1:0] ki;
    logic [31:0]                   pend = 32'h0;
    int                            n_mismatch = 0;
    int                            total_checks = 0;
    pwtc_link_if link ();
    pwtc_device u_pwtc_device (.core_clk_i(core_clk), .rstn_i(rstn), .link(link),
        .phase_sync_i(sync), .current_mode_i(cmode), .phase_aligned_o(aligned),
        .period_start_o(pstart), .adc_sample_o(adc), .sample_sum_method_o(sample_sum_method),
        .kp_o(kp), .ki_o(ki));
    pwtc_host u_pwtc_host (.core_clk_i(core_clk), .rstn_i(rstn), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .link(link));
    pwtc_properties u_pwtc_properties (.core_clk_i(core_clk), .rstn_i(rstn),
        .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso));
    always #10 core_clk = ~core_clk;
    function automatic logic [31:0] pw(input logic w, input logic [2:0] c, input logic [16:0] f);
        return {w, MSG_PERIOD, c, 7'h00, f};
    endfunction : pw
    function automatic logic [31:0] gw(input logic w, input logic [2:0] c, input logic [23:0] f);
        return {w, MSG_GAINS, c, f};
    endfunction : gw
    task automatic summarize;
        if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    task automatic stop(input string what);
        n_mismatch++;
        $display("Error %s expected pulse seen timeout", what);
        summarize;
    endtask : stop
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bus_wr(input logic [1:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr    <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [1:0] a, output logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : bus_rd
    // Reply of a frame belongs to the request before it
    task automatic send(input logic [31:0] req, input logic [31:0] exp);
        logic [31:0] st;
        int i;
        bus_wr(HOST_ADDR_TX, req);
        for (i = 0; i < 1000; i++) begin
            bus_rd(HOST_ADDR_STAT, st);
            if (st[1:0] == 2'b10) break;
        end
        if (i == 1000) stop("frame");
        bus_rd(HOST_ADDR_RX, st);
        chk("reply", pend, st);
        pend = exp;
    endtask : send
    // Cycles between two pulses of one channel
    task automatic gap(input int ch, input bit a, output int n);
        int i;
        n = 0;
        for (i = 0; i < 6000; i++) begin
            // Sampled mid-cycle, clear of the edge that launches the pulse
            @(negedge core_clk);
            if ((a ? adc[ch] : pstart[ch]) === 1'b1) begin
                if (n > 0) break;
                n = 1;
            end else if (n > 0) n++;
        end
        if (i == 6000) stop("gap");
    endtask : gap
    task automatic t_defaults;
        int c;
        send({1'b0, MSG_OFF_LOW, 24'h0}, {1'b0, MSG_OFF_LOW, 24'h0});
        send({1'b0, MSG_OFF_HIGH, 24'h0}, {1'b0, MSG_OFF_HIGH, 24'h0});
        for (c = 0; c < NUM_CH; c++)
            send(pw(1'b0, c[2:0], 17'h0), pw(1'b0, c[2:0], {SAM_RST, MDIV_RST, NDIV_RST}));
        send(gw(1'b0, 3'h7, 24'h0), gw(1'b0, 3'h7, 24'h0));
        chk("sample method", 32'h0, {24'h0, sample_sum_method});
    endtask : t_defaults
    task automatic t_regs;
        send({1'b1, MSG_OFF_HIGH, 4'h0, 20'hA5A5A}, {1'b0, MSG_OFF_HIGH, 4'h0, 20'hA5A5A});
        send({1'b0, MSG_OFF_HIGH, 4'hF, 20'h5A5A5}, {1'b0, MSG_OFF_HIGH, 4'h0, 20'hA5A5A});
        send({1'b1, MSG_OFF_LOW, 4'h0, 20'h00100}, {1'b0, MSG_OFF_LOW, 4'h0, 20'h00100});
        send({1'b1, 7'h30, 24'hFFFFFF}, 32'h0);
    endtask : t_regs
    task automatic t_phase;
        int t;
        int t0;
        int t1;
        send(pw(1'b1, 3'h0, 17'h00004), pw(1'b0, 3'h0, 17'h00004));
        send(pw(1'b1, 3'h1, 17'h00004), pw(1'b0, 3'h1, 17'h00004));
        chk("aligned before sync", 32'h0, {31'h0, aligned});
        @(posedge core_clk);
        sync <= 1'b1;
        repeat (2) @(posedge core_clk);
        sync <= 1'b0;
        repeat (8) @(posedge core_clk);
        t0 = -1;
        t1 = -1;
        for (t = 0; t < 300 && t1 < 0; t++) begin
            @(negedge core_clk);
            if (pstart[0] === 1'b1 && t0 < 0) t0 = t;
            else if (pstart[1] === 1'b1 && t0 >= 0) t1 = t;
        end
        chk("aligned after sync", 32'h1, {31'h0, aligned});
        chk("channel 1 delay", 32'd32, t1 - t0);
    endtask : t_phase
    task automatic t_period;
        int m;
        int n;
        int ep;
        logic [16:0] f;
        for (m = 0; m < 5; m++) begin
            f = {m == 1, (m == 4) ? 2'h3 : m[1:0], 14'h0004};
            ep = (m < 3) ? (128 << m) : ((m == 3) ? 2048 : 512);
            @(posedge core_clk);
            cmode <= (m == 4);
            send(pw(1'b1, 3'h3, f), pw(1'b0, 3'h3, f));
            gap(3, 1'b0, n);
            gap(3, 1'b0, n);
            chk("period", ep, n);
            gap(3, 1'b1, n);
            chk("adc interval", 32'd4, n);
            chk("sample method", {31'h0, m == 1}, {31'h0, sample_sum_method[3]});
        end
    endtask : t_period
    task automatic t_gains;
        send(gw(1'b1, 3'h5, 24'hABC123), gw(1'b0, 3'h5, 24'hABC123));
        chk("kp", 32'hABC, {20'h0, kp[5]});
        chk("ki", 32'h123, {20'h0, ki[5]});
        chk("kp other", 32'h0, {20'h0, kp[4]});
        send(gw(1'b0, 3'h5, 24'h0), gw(1'b0, 3'h5, 24'hABC123));
        send(gw(1'b0, 3'h4, 24'h0), gw(1'b0, 3'h4, 24'h0));
    endtask : t_gains
    // Mid-run reset must restore defaults and drop alignment
    task automatic t_reset;
        send(32'h0, 32'h0);
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("aligned after reset", 32'h0, {31'h0, aligned});
        chk("kp after reset", 32'h0, {20'h0, kp[5]});
        send(gw(1'b0, 3'h5, 24'h0), gw(1'b0, 3'h5, 24'h0));
        send(pw(1'b0, 3'h1, 17'h0), pw(1'b0, 3'h1, {SAM_RST, MDIV_RST, NDIV_RST}));
        send(32'h0, 32'h0);
    endtask : t_reset
    initial begin
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_defaults;
        t_regs;
        t_phase;
        t_period;
        t_gains;
        t_reset;
        summarize;
    end
endmodule : pwm_timing_config_tb_top
`default_nettype wire
